// file: inc/pwm_defines.vh
// Constants for the three-channel PWM block: register byte offsets,
// control field positions, reset values and phase counts.
// Assumes a 32-bit AXI4-Lite register bus with 8-bit addresses.
`ifndef PWM_DEFINES_VH
`define PWM_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define A_CTRL      8'h00
`define A_PER_ONE   8'h04
`define A_PER_TWO   8'h08
`define A_CNT_ONE   8'h0C
`define A_CNT_TWO   8'h10
`define A_FLAGS     8'h14
`define A_PORT_DIR  8'h18
`define A_PORT_DATA 8'h1C
`define A_CH_BASE   8'h20
`define A_CH_STRIDE 8'h08
`define A_CH_LO     8'h04
`define A_LAST      8'h34

// ****************************************
// Control field positions
// ****************************************
`define B_T1_ON     0
`define B_T2_ON     1
`define B_T1_EXT    2
`define B_T2_EXT    3
`define B_CH_EN     4
`define B_TB_SEL    5
`define B_DUTY_LO   6

// ****************************************
// Reset values
// ****************************************
`define R_CTRL      8'h00
`define R_PERIOD    8'hFF
`define R_DIR       3'h7
`define R_DATA      3'h0

// ****************************************
// Timing and bus answers
// ****************************************
`define PHASES_LAST 2'h3
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// file: logic/triple_pwm.v
// Three PWM channels on two shared 8-bit period timers, AXI4-Lite slave.
// Assumes mclk_i is the oscillator clock; four cycles make one
// instruction cycle. All inputs are synchronous to mclk_i.
// Duty registers read back the active, not the held, values.
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Three outputs; channel one on timer one
// - Ten-bit duty value per channel
// - Duty spans always low to always high
// - Channel one enable forces pin driving
// - Disabled channel pin follows direction bit
// - Channels two, three enables act alike
// - Channel two selects timer one or two
// - Channel three selects timer one or two
// - Period is (period reg + 1) times four
// - Duty is high byte plus bits 7:6
// - High time equals duty oscillator periods
// - Zero duty keeps output low
// - High byte equal period gives short low
// - Full high only when byte exceeds period
// - Held duty moves active at roll-over
// - Timer flag set at roll-over
// - PWM works on internal or external clock
// - External clock sampled once per cycle
// - External clock: low duty bits zero; here still compared with phase
// - Timer counts zero to period, wraps
module triple_pwm (
	input  wire        mclk_i,
	input  wire        sys_rst_i,
	// AXI4-Lite register slave
	input  wire [7:0]  s_awaddr_i,
	input  wire        s_awvalid_i,
	output wire        s_awready_o,
	input  wire [31:0] s_wdata_i,
	input  wire [3:0]  s_wstrb_i,
	input  wire        s_wvalid_i,
	output wire        s_wready_o,
	output reg  [1:0]  s_bresp_o,
	output reg         s_bvalid_o,
	input  wire        s_bready_i,
	input  wire [7:0]  s_araddr_i,
	input  wire        s_arvalid_i,
	output wire        s_arready_o,
	output reg  [31:0] s_rdata_o,
	output reg  [1:0]  s_rresp_o,
	output reg         s_rvalid_o,
	input  wire        s_rready_i,
	// Timer clock and port pins
	input  wire        ext_timer_clock_pin_i,
	input  wire [2:0]  pwm_pin_i,
	output wire [2:0]  pwm_pin_o,
	output wire [2:0]  pwm_pin_oe_o
);

`include "pwm_defines.vh"

// ****************************************
// Register bus, write side
// ****************************************
reg         aw_hold_q;
reg  [7:0]  aw_addr_q;
reg         w_hold_q;
reg  [31:0] w_data_q;
reg         w_strb_q;
wire        aw_take;
wire        w_take;
wire        aw_has;
wire        w_has;
wire [7:0]  wr_addr;
wire [31:0] wr_data;
wire        wr_strb;
wire        do_wr;
wire        wr_en;

// Word aligned and inside the register map
function mapped;
	input [7:0] a;
	begin
		mapped = (a[1:0] == 2'h0) && (a <= `A_LAST);
	end
endfunction

// Address and data are taken in either order; each is parked
// until its partner arrives, and both wait while B is pending
assign s_awready_o = ~aw_hold_q & ~s_bvalid_o;
assign s_wready_o  = ~w_hold_q & ~s_bvalid_o;
assign aw_take     = s_awvalid_i & s_awready_o;
assign w_take      = s_wvalid_i & s_wready_o;
assign aw_has      = aw_hold_q | aw_take;
assign w_has       = w_hold_q | w_take;
assign wr_addr     = aw_hold_q ? aw_addr_q : s_awaddr_i;
assign wr_data     = w_hold_q ? w_data_q : s_wdata_i;
assign wr_strb     = w_hold_q ? w_strb_q : s_wstrb_i[0];
assign do_wr       = aw_has & w_has & ~s_bvalid_o;
assign wr_en       = do_wr & wr_strb & mapped(wr_addr);

// Response is issued once both halves are in hand
always @(posedge mclk_i) begin
	if (sys_rst_i) begin
		aw_hold_q  <= 1'b0;
		aw_addr_q  <= 8'h00;
		w_hold_q   <= 1'b0;
		w_data_q   <= 32'h00000000;
		w_strb_q   <= 1'b0;
		s_bvalid_o <= 1'b0;
		s_bresp_o  <= `RESP_OKAY;
	end else if (do_wr) begin
		aw_hold_q  <= 1'b0;
		w_hold_q   <= 1'b0;
		s_bvalid_o <= 1'b1;
		s_bresp_o  <= mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
	end else begin
		if (aw_take) begin
			aw_hold_q <= 1'b1;
			aw_addr_q <= s_awaddr_i;
		end
		if (w_take) begin
			w_hold_q <= 1'b1;
			w_data_q <= s_wdata_i;
			w_strb_q <= s_wstrb_i[0];
		end
		if (s_bvalid_o && s_bready_i)
			s_bvalid_o <= 1'b0;
	end
end

// ****************************************
// Control registers
// ****************************************
reg  [7:0] ctrl_q;
reg  [7:0] period_reg_one_q;
reg  [7:0] period_reg_two_q;
reg  [2:0] port_b_direction_q;
reg  [2:0] port_data_q;
reg  [1:0] rollover_flag_q;
wire [1:0] roll;

// Counts at 0C and 10 are read only; writes there are dropped
always @(posedge mclk_i) begin
	if (sys_rst_i) begin
		ctrl_q             <= `R_CTRL;
		period_reg_one_q   <= `R_PERIOD;
		period_reg_two_q   <= `R_PERIOD;
		port_b_direction_q <= `R_DIR;
		port_data_q        <= `R_DATA;
	end else if (wr_en) begin
		case (wr_addr)
		`A_CTRL:      ctrl_q             <= wr_data[7:0];
		`A_PER_ONE:   period_reg_one_q   <= wr_data[7:0];
		`A_PER_TWO:   period_reg_two_q   <= wr_data[7:0];
		`A_PORT_DIR:  port_b_direction_q <= wr_data[2:0];
		`A_PORT_DATA: port_data_q        <= wr_data[2:0];
		default:      ctrl_q             <= ctrl_q;
		endcase
	end
end

// Write one to clear; a roll-over in the same cycle wins
wire       clr_flags = wr_en && (wr_addr == `A_FLAGS);
wire [1:0] flag_clr  = {2{clr_flags}} & wr_data[1:0];
wire [1:0] rollover_flag_d;

// Flags stay set until software writes ones to them
assign rollover_flag_d = roll | (rollover_flag_q & ~flag_clr);

always @(posedge mclk_i) begin
	if (sys_rst_i)
		rollover_flag_q <= 2'h0;
	else
		rollover_flag_q <= rollover_flag_d;
end

// ****************************************
// Phase counter and external clock sampling
// ****************************************
reg  [1:0] phase_q;
reg        ext_s1_q;
reg        ext_s2_q;
reg        ext_s3_q;
wire       instr_en;
wire       ext_fall;

// Four oscillator phases make one instruction cycle; timers
// and the external sampler move on the last one
assign instr_en = (phase_q == `PHASES_LAST);

always @(posedge mclk_i) begin
	if (sys_rst_i)
		phase_q <= 2'h0;
	else
		phase_q <= phase_q + 2'h1;
end

// Sampled once per instruction cycle through three stages, so a falling edge counts two to three cycles late
always @(posedge mclk_i) begin
	if (sys_rst_i) begin
		ext_s1_q <= 1'b1;
		ext_s2_q <= 1'b1;
		ext_s3_q <= 1'b1;
	end else if (instr_en) begin
		ext_s1_q <= ext_timer_clock_pin_i;
		ext_s2_q <= ext_s1_q;
		ext_s3_q <= ext_s2_q;
	end
end

// Flops reset high: an idle-high pin gives no edge at start
assign ext_fall = ext_s3_q & ~ext_s2_q;

// ****************************************
// Period timers
// ****************************************
wire [15:0] count_all;
wire [15:0] period_all;

assign period_all = {period_reg_two_q, period_reg_one_q};

// Each timer counts zero to its period, then wraps; the wrap
// is the roll-over that starts a new output period
genvar t;
generate
	for (t = 0; t < 2; t = t + 1) begin : g_tmr
		reg  [7:0] cnt_q;
		wire       ext_sel = ctrl_q[`B_T1_EXT + t];
		wire       run = ctrl_q[`B_T1_ON + t];
		// Internal source steps every instruction cycle
		wire       tick = ~ext_sel | ext_fall;
		wire       inc = instr_en & run & tick;
		wire       at_per = (cnt_q == period_all[8*t+7:8*t]);
		assign roll[t] = inc & at_per;
		assign count_all[8*t+7:8*t] = cnt_q;
		always @(posedge mclk_i) begin
			if (sys_rst_i)
				cnt_q <= 8'h00;
			else if (inc)
				cnt_q <= at_per ? 8'h00 : cnt_q + 8'h01;
		end
	end
endgenerate

// ****************************************
// PWM channels
// ****************************************
wire [29:0] act_all;
wire [2:0]  tb_all;
wire [2:0]  pwm_out;

// A write lands in the held copy; it becomes active only at the
// roll-over of the chosen timer, so a period never mixes two
// duty values
genvar i;
generate
	for (i = 0; i < 3; i = i + 1) begin : g_ch
		localparam integer HI_N = `A_CH_BASE + i * `A_CH_STRIDE;
		localparam [7:0]   A_HI = HI_N[7:0];
		localparam [7:0] A_LO = A_HI + `A_CH_LO;
		reg  [7:0] held_hi_q;
		reg  [1:0] held_lo_q;
		reg        tb_sel_q;
		reg  [9:0] duty_value_q;
		reg        out_q;

		wire [9:0] held = {held_hi_q, held_lo_q};
		// Channel one never selects timer two
		wire       use_two = (i != 0) & tb_sel_q;
		wire       ch_roll = use_two ? roll[1] : roll[0];
		wire [7:0] ch_cnt = use_two ? count_all[15:8] : count_all[7:0];
		// Position after this phase, one bit wider to avoid wrap
		wire [10:0] pos_next = {1'b0, ch_cnt, phase_q} + 11'h001;

		always @(posedge mclk_i) begin
			if (sys_rst_i) begin
				held_hi_q <= 8'h00;
				held_lo_q <= 2'h0;
				tb_sel_q  <= 1'b0;
			end else if (wr_en && wr_addr == A_HI) begin
				held_hi_q <= wr_data[7:0];
			end else if (wr_en && wr_addr == A_LO) begin
				held_lo_q <= wr_data[`B_DUTY_LO + 1:`B_DUTY_LO];
				tb_sel_q  <= (i != 0) & wr_data[`B_TB_SEL];
			end
		end

		// Output rises at roll-over and falls where the position
		// meets the duty; roll-over wins when both share an edge
		always @(posedge mclk_i) begin
			if (sys_rst_i) begin
				duty_value_q <= 10'h000;
				out_q        <= 1'b0;
			end else if (ch_roll) begin
				duty_value_q <= held;
				out_q        <= (held != 10'h000);
			end else if (pos_next == {1'b0, duty_value_q}) begin
				// Never matches if duty exceeds (period + 1) times four
				out_q <= 1'b0;
			end
		end

		assign act_all[10*i+9:10*i] = duty_value_q;
		assign tb_all[i]  = tb_sel_q;
		assign pwm_out[i] = out_q;
	end
endgenerate

// ****************************************
// Pins
// ****************************************
wire [2:0] chan_en = ctrl_q[`B_CH_EN + 2:`B_CH_EN];

// Direction bit set means input
// An enabled channel drives whatever its direction bit says
assign pwm_pin_oe_o = chan_en | ~port_b_direction_q;
assign pwm_pin_o    = (chan_en & pwm_out) |
	(~chan_en & port_data_q);

// ****************************************
// Register bus, read side
// ****************************************
reg [7:0] rd_byte;
wire      ar_take = s_arvalid_i & s_arready_o;

// One read at a time: the next address waits for rready
assign s_arready_o = ~s_rvalid_o;

// Duty reads show the active values, not the held ones
always @* begin
	case (s_araddr_i)
	`A_CTRL:      rd_byte = ctrl_q;
	`A_PER_ONE:   rd_byte = period_reg_one_q;
	`A_PER_TWO:   rd_byte = period_reg_two_q;
	`A_CNT_ONE:   rd_byte = count_all[7:0];
	`A_CNT_TWO:   rd_byte = count_all[15:8];
	`A_FLAGS:     rd_byte = {6'h00, rollover_flag_q};
	`A_PORT_DIR:  rd_byte = {5'h00, port_b_direction_q};
	`A_PORT_DATA: rd_byte = {5'h00, pwm_pin_i};
	8'h20:        rd_byte = act_all[9:2];
	8'h24:        rd_byte = {act_all[1:0], tb_all[0], 5'h00};
	8'h28:        rd_byte = act_all[19:12];
	8'h2C:        rd_byte = {act_all[11:10], tb_all[1], 5'h00};
	8'h30:        rd_byte = act_all[29:22];
	8'h34:        rd_byte = {act_all[21:20], tb_all[2], 5'h00};
	default:      rd_byte = 8'h00;
	endcase
end

// Data and response latch with rvalid and hold until taken
always @(posedge mclk_i) begin
	if (sys_rst_i) begin
		s_rvalid_o <= 1'b0;
		s_rdata_o  <= 32'h00000000;
		s_rresp_o  <= `RESP_OKAY;
	end else if (ar_take) begin
		s_rvalid_o <= 1'b1;
		s_rdata_o  <= {24'h000000, rd_byte};
		s_rresp_o  <= mapped(s_araddr_i) ? `RESP_OKAY : `RESP_SLVERR;
	end else if (s_rready_i) begin
		s_rvalid_o <= 1'b0;
	end
end

endmodule

`default_nettype wire

// file: verification/triple_pwm_asserts.sv
// Checker for the triple_pwm register bus handshake and pin enables.
// Assumes it is bound to the ports of the triple_pwm top module.
`timescale 1ns/1ps
`default_nettype none
module triple_pwm_asserts (
	input wire logic        mclk_i,
	input wire logic        sys_rst_i,
	input wire logic        s_awvalid_i,
	input wire logic        s_awready_o,
	input wire logic        s_wvalid_i,
	input wire logic        s_wready_o,
	input wire logic [1:0]  s_bresp_o,
	input wire logic        s_bvalid_o,
	input wire logic        s_bready_i,
	input wire logic        s_arvalid_i,
	input wire logic        s_arready_o,
	input wire logic [31:0] s_rdata_o,
	input wire logic        s_rvalid_o,
	input wire logic        s_rready_i,
	input wire logic [2:0]  pwm_pin_oe_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_wr;
		s_awvalid_i && s_awready_o && s_wvalid_i && s_wready_o;
	endsequence
	sequence s_rd;
		s_arvalid_i && s_arready_o;
	endsequence
	property p_wr_ans; s_wr |=> s_bvalid_o; endproperty
	property p_b_hold;
		s_bvalid_o && !s_bready_i |=> s_bvalid_o && $stable(s_bresp_o);
	endproperty
	property p_b_block; s_bvalid_o |-> !s_awready_o && !s_wready_o; endproperty
	property p_b_done; s_bvalid_o && s_bready_i |=> !s_bvalid_o; endproperty
	property p_rd_ans; s_rd |=> s_rvalid_o; endproperty
	property p_r_hold;
		s_rvalid_o && !s_rready_i |=> s_rvalid_o && $stable(s_rdata_o);
	endproperty
	property p_r_block; s_rvalid_o |-> !s_arready_o; endproperty
	property p_rst;
		disable iff (1'b0) sys_rst_i |=> pwm_pin_oe_o == 3'h0 && !s_bvalid_o;
	endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("no write answer");
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	a_b_block: assert property (p_b_block) else $error("write taken early");
	a_b_done: assert property (p_b_done) else $error("write answer stuck");
	a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	a_r_block: assert property (p_r_block) else $error("read taken early");
	a_rst: assert property (p_rst) else $error("pins drive in reset");
endmodule
bind triple_pwm triple_pwm_asserts u_chk (.mclk_i, .sys_rst_i, .s_awvalid_i,
	.s_awready_o, .s_wvalid_i, .s_wready_o, .s_bresp_o, .s_bvalid_o,
	.s_bready_i, .s_arvalid_i, .s_arready_o, .s_rdata_o, .s_rvalid_o,
	.s_rready_i, .pwm_pin_oe_o);
`default_nettype wire

// file: verification/triple_pwm_with_shared_timebase_test.sv
// Self-checking bench for triple_pwm: bus tasks, pin counts, duty model.
// Assumes a 50 ns clock and the register map of pwm_defines.vh.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_defines.vh"
module triple_pwm_with_shared_timebase_test;
	logic        mclk_i, sys_rst_i, ext_en, awv, wv, bry, arv, rry;
	logic        ext = 1'b1;
	logic [7:0]  awa, ara, rv;
	logic [31:0] wd, seed;
	logic [2:0]  pin_in;
	logic [1:0]  rr;
	logic [9:0]  tab [8];
	wire         awr, wr_r, bv, arr, rvl;
	wire  [1:0]  br, rsp;
	wire  [31:0] rdt;
	wire  [2:0]  pin_o, oe;
	int          errors, samples_checked, per, hi, d;
	int          cyc = 0;
	triple_pwm dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
		.s_awaddr_i(awa), .s_awvalid_i(awv), .s_awready_o(awr),
		.s_wdata_i(wd), .s_wstrb_i(4'hF), .s_wvalid_i(wv), .s_wready_o(wr_r),
		.s_bresp_o(br), .s_bvalid_o(bv), .s_bready_i(bry),
		.s_araddr_i(ara), .s_arvalid_i(arv), .s_arready_o(arr),
		.s_rdata_o(rdt), .s_rresp_o(rsp), .s_rvalid_o(rvl), .s_rready_i(rry),
		.ext_timer_clock_pin_i(ext), .pwm_pin_i(pin_in), .pwm_pin_o(pin_o),
		.pwm_pin_oe_o(oe));
	// ****************************************
	// Tasks
	// ****************************************
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// Model: high phases and rises in a window of w phases
	function automatic int exp_high(input int dv, pr, w);
		if (dv == 0)
			return 0;
		if ((dv >> 2) > pr)
			return w;
		return dv * (w / (4 * (pr + 1)));
	endfunction
	function automatic int exp_rises(input int dv, pr, w);
		if (dv == 0 || (dv >> 2) > pr)
			return 0;
		return w / (4 * (pr + 1));
	endfunction
	task automatic chk(input string n, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task automatic near(input string n, input int e, g, t);
		samples_checked++;
		if (g > e + t || g < e - t) begin
			errors++;
			$display("[FAIL] %s expected %0d seen %0d", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, v);
		logic ta, tw, tb;
		@(posedge mclk_i);
		awa <= a;
		wd <= {24'h0, v};
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		do begin
			@(negedge mclk_i);
			ta = awv && awr;
			tw = wv && wr_r;
			tb = bv;
			@(posedge mclk_i);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end while (!tb);
		bry <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		logic ta, tb;
		@(posedge mclk_i);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do begin
			@(negedge mclk_i);
			ta = arv && arr;
			tb = rvl;
			rv = rdt[7:0];
			rr = rsp;
			@(posedge mclk_i);
			if (ta) arv <= 1'b0;
		end while (!tb);
		rry <= 1'b0;
	endtask
	task automatic meas(input int c, w);
		logic l;
		@(negedge mclk_i);
		l = pin_o[c];
		per = 0;
		hi = 0;
		repeat (w) begin
			@(negedge mclk_i);
			hi += pin_o[c];
			per += (pin_o[c] && !l);
			l = pin_o[c];
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ****************************************
	// Stimulus
	// ****************************************
	initial begin
		mclk_i = 1'b0;
		forever #25 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		pin_in <= (oe & pin_o) | (~oe & 3'h5);
		if (ext_en && cyc[3:0] == 4'h0) ext <= ~ext;
		if (cyc == 40000) begin
			errors++;
			summarize();
		end
	end
	initial begin
		{awv, wv, bry, arv, rry, ext_en, awa, ara, wd} = '0;
		{errors, samples_checked} = '0;
		sys_rst_i = 1'b1;
		seed = 32'h002CA521;
		tab = '{10'h000, 10'h006, 10'h001, 10'h00C, 10'h00F, 0, 0, 10'h010};
		repeat (6) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		rd(`A_CTRL);
		chk("ctrl", `R_CTRL, rv);
		rd(`A_PER_ONE);
		chk("period", `R_PERIOD, rv);
		rd(`A_PORT_DIR);
		chk("dir", `R_DIR, rv);
		chk("oe", 3'h0, oe);
		rd(8'h38);
		chk("resp", `RESP_SLVERR, rr);
		rd(`A_PORT_DATA);
		chk("pins", 3'h5, rv);
		wr(`A_PORT_DIR, 8'h00);
		wr(`A_PORT_DATA, 8'h02);
		rd(`A_PORT_DATA);
		chk("pins", 3'h2, rv);
		chk("oe", 3'h7, oe);
		wr(`A_PER_ONE, 8'h03);
		wr(`A_PER_TWO, 8'h01);
		wr(`A_PORT_DIR, 8'h07);
		wr(8'h2C, 8'hA0);
		wr(8'h34, 8'h80);
		wr(`A_CTRL, 8'h73);
		chk("oe", 3'h7, oe);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			d = (i == 5 || i == 6) ? seed[3:0] : tab[i];
			wr(8'h20, d[9:2]);
			wr(8'h24, {d[1:0], 6'h20});
			repeat (40) @(posedge mclk_i);
			meas(0, 64);
			chk("high", exp_high(d, 3, 64), hi);
			chk("rises", exp_rises(d, 3, 64), per);
			rd(8'h20);
			chk("duty_hi", d[9:2], rv);
			rd(8'h24);
			chk("duty_lo", d[1:0], rv[7:6]);
			chk("ch1_tb", 1'b0, rv[5]);
		end
		meas(1, 64);
		chk("rises2", exp_rises(2, 1, 64), per);
		chk("high2", exp_high(2, 1, 64), hi);
		meas(2, 64);
		chk("rises3", exp_rises(2, 3, 64), per);
		chk("high3", exp_high(2, 3, 64), hi);
		rd(`A_FLAGS);
		chk("flags", 2'h3, rv[1:0]);
		rd(`A_CNT_ONE);
		chk("count", 1'b1, rv <= 8'h03);
		wr(`A_CTRL, 8'h70);
		wr(`A_FLAGS, 8'h03);
		rd(`A_FLAGS);
		chk("flags_clr", 2'h0, rv[1:0]);
		wr(8'h20, 8'h02);
		wr(8'h24, 8'h00);
		wr(`A_CTRL, 8'h77);
		ext_en <= 1'b1;
		repeat (300) @(posedge mclk_i);
		meas(0, 1024);
		near("ext_rises", 8, per, 1);
		rd(`A_FLAGS);
		chk("flags_set", 2'h3, rv[1:0]);
		summarize();
	end
endmodule
`default_nettype wire
